// *** common/itsc_defines.svh ***
/*
 * Holds the numeric constants of the interrupt, test-input and standby controller:
 * source count, vector table layout, break vector and reset values.
 * Assumes it is included by its bare name from the package and the design modules.
 */
`ifndef ITSC_DEFINES_SVH
`define ITSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// maskable sources and vector table
// ----------------------------------------------------------------------------
`define ITSC_NUM_SRC        20
`define ITSC_SRC_ADC_DONE   5'd18
`define ITSC_SRC_BUS_CTRL   5'd19
`define ITSC_VEC_BASE       16'h0004
`define ITSC_VEC_STEP       16'h0002
`define ITSC_VEC_ADC_DONE   16'h0028
`define ITSC_VEC_BUS_CTRL   16'h002A
`define ITSC_VEC_BREAK      16'h003E

// ----------------------------------------------------------------------------
// test inputs
// ----------------------------------------------------------------------------
`define ITSC_NUM_TEST       2
`define ITSC_TEST_WATCH     0
`define ITSC_TEST_PORT      1
`define ITSC_PORT_WIDTH     8
`define ITSC_PORT_RESET     8'hFF

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ITSC_FLAGS_RESET    20'h00000
`define ITSC_VEC_RESET      16'h0000
`define ITSC_ID_RESET       5'h00
`define ITSC_TFLAG_RESET    2'h0

`endif

// *** common/itsc_pkg.sv ***
/*
 * Holds the types of the interrupt, test-input and standby controller:
 * standby state encoding and the packed state records of both modules.
 * Assumes itsc_defines.svh is reachable on the include path.
 */
`include "itsc_defines.svh"

package itsc_pkg;

	// ------------------------------------------------------------------------
	// standby modes
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_HALT = 2'b01,
		ST_STOP = 2'b10
	} standby_type;

	// ------------------------------------------------------------------------
	// state records
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [`ITSC_NUM_SRC-1:0] req_flags;
		logic                     irq_req;
		logic [4:0]               irq_id;
		logic [15:0]              vector;
		logic                     break_trap;
		standby_type              standby;
		logic                     cpu_clk_en;
		logic                     main_osc_en;
		logic                     sys_reset;
	} ctrl_state_type;

	typedef struct packed {
		logic [`ITSC_PORT_WIDTH-1:0] port_prev;
		logic [`ITSC_NUM_TEST-1:0]   flags;
		logic                        wake;
	} test_state_type;

endpackage : itsc_pkg

// *** common/test_input_if.sv ***
/*
 * Carries the test-input signals between the controller top and its test unit.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/10ps
`include "itsc_defines.svh"

interface test_input_if;
	logic                        watch_ovf;
	logic [`ITSC_PORT_WIDTH-1:0] port_in;
	logic [`ITSC_NUM_TEST-1:0]   test_mask;
	logic [`ITSC_NUM_TEST-1:0]   test_clr;
	logic [`ITSC_NUM_TEST-1:0]   test_flags;
	logic                        test_wake;

	modport unit (input watch_ovf, input port_in, input test_mask, input test_clr,
		output test_flags, output test_wake);
	modport ctrl (output watch_ovf, output port_in, output test_mask, output test_clr,
		input test_flags, input test_wake);
endinterface : test_input_if

// *** rtl/test_input_unit.sv ***
/*
 * Holds the test-input unit: watch-timer overflow and port falling-edge flags,
 * each with its own mask; an unmasked flag raises the wake level.
 * Assumes all inputs are synchronous to core_clk.
 */
`timescale 1ns/10ps
`include "itsc_defines.svh"

module test_input_unit
	import itsc_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// test signals
	test_input_if.unit tif
);
	test_state_type s_q;
	test_state_type s_d;

	// ------------------------------------------------------------------------
	// flag logic
	// ------------------------------------------------------------------------
	// set beats clear so an edge in the clearing cycle is kept
	always_comb
	begin
		s_d           = s_q;
		s_d.port_prev = tif.port_in;
		s_d.flags     = s_q.flags & ~tif.test_clr;
		if (tif.watch_ovf)
			s_d.flags[`ITSC_TEST_WATCH] = 1'b1;                          // see RQ6
		if (|(s_q.port_prev & ~tif.port_in))
			s_d.flags[`ITSC_TEST_PORT] = 1'b1;                           // see RQ7
		s_d.wake = |(s_d.flags & ~tif.test_mask);                       // see RQ8
	end

	// port history resets high so a pin low at start counts as a falling edge
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_q.port_prev <= `ITSC_PORT_RESET;
			s_q.flags     <= `ITSC_TFLAG_RESET;
			s_q.wake      <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign tif.test_flags = s_q.flags;
	assign tif.test_wake  = s_q.wake;

endmodule : test_input_unit

// *** rtl/interrupt_test_standby_ctrl.sv ***
/*
 * Holds the interrupt, test-input and standby controller top: maskable request
 * flags with masks and levels, priority selection and vectoring, break trap,
 * HALT/STOP standby with clock enables, main oscillator shutdown and reset merge.
 * Assumes all inputs are synchronous to core_clk and the CPU acknowledges a request
 * with a one-cycle pulse.
 */
`timescale 1ns/10ps
`include "itsc_defines.svh"

// Operation
// RQ1 - ADC completion requests at priority 18, vector 0028H.
// RQ2 - Bus-controller request at priority 19, vector 002AH, every code write or runaway.
// RQ3 - Break instruction always traps to 003EH regardless of masks or priorities.
// RQ4 - Among pending maskable requests the lowest priority number wins; code serves high-level requests first, lowest number within a level.
// RQ5 - Each source has request, mask, level flags; global enable and in-service level gate.
// RQ6 - Watch timer overflow sets its own test flag, apart from interrupts.
// RQ7 - Falling edge on any port-4 input sets the external test flag.
// RQ8 - Each test flag has its own mask; masked flags do not act.
// RQ9 - HALT stops the CPU clock, oscillators keep running.
// RQ10 - STOP halts main oscillator; only subsystem-clocked logic runs.
// RQ11 - On subsystem clock the stop bit shuts main oscillator; STOP unusable then.
// RQ12 - Software waits oscillation settling before returning to main clock.
// RQ13 - Device resets from low reset pin or watchdog runaway.
// RQ14 - Forward only unmasked, globally enabled requests above the in-service level.
module interrupt_test_standby_ctrl
	import itsc_pkg::*;
#(
	parameter int NUM_SRC = `ITSC_NUM_SRC
)
(
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// reset sources
	input  wire logic                        reset_pin_n,
	input  wire logic                        watchdog_runaway,
	// peripheral request pulses, one per default priority
	input  wire logic [NUM_SRC-1:0]          irq_src,
	// per-source and global configuration
	input  wire logic [NUM_SRC-1:0]          mask_bit,
	input  wire logic [NUM_SRC-1:0]          level_select_flag,
	input  wire logic [NUM_SRC-1:0]          req_flag_clr,
	input  wire logic                        global_irq_enable,
	input  wire logic                        in_service_level,
	// cpu handshake
	input  wire logic                        irq_ack,
	input  wire logic                        break_exec,
	input  wire logic                        halt_exec,
	input  wire logic                        stop_exec,
	// clock control
	input  wire logic                        cpu_on_subclk,
	input  wire logic                        main_clock_stop_bit,
	// test inputs
	input  wire logic                        watch_overflow_test,
	input  wire logic [`ITSC_PORT_WIDTH-1:0] port_falling_test,
	input  wire logic [`ITSC_NUM_TEST-1:0]   test_mask,
	input  wire logic [`ITSC_NUM_TEST-1:0]   test_clr,
	// request and trap outputs
	output logic                             irq_req,
	output logic [4:0]                       irq_id,
	output logic [15:0]                      irq_vector,
	output logic                             break_trap,
	output logic [NUM_SRC-1:0]               req_flags,
	output logic [`ITSC_NUM_TEST-1:0]        test_flags,
	output logic                             test_wake,
	// clock and reset outputs
	output logic                             cpu_clk_en,
	output logic                             main_osc_en,
	output logic                             sys_reset
);
	import itsc_pkg::*;

	ctrl_state_type s_q;
	ctrl_state_type s_d;
	test_input_if   tif ();

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// vector table is evenly spaced from the base, two bytes per source
	function automatic logic [15:0] vector_of(input logic [4:0] id);
		vector_of = `ITSC_VEC_BASE + (`ITSC_VEC_STEP * {11'h000, id});   // see RQ1, RQ2
	endfunction : vector_of

	// lowest set index of a request vector; found flag in the msb
	function automatic logic [5:0] first_set(input logic [NUM_SRC-1:0] v);
		first_set = 6'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--)
			if (v[i])
				first_set = {1'b1, i[4:0]};                             // see RQ4
	endfunction : first_set

	// ------------------------------------------------------------------------
	// test unit
	// ------------------------------------------------------------------------
	assign tif.watch_ovf = watch_overflow_test;
	assign tif.port_in   = port_falling_test;
	assign tif.test_mask = test_mask;
	assign tif.test_clr  = test_clr;

	test_input_unit u_test (
		.core_clk (core_clk),
		.rst      (rst),
		.tif      (tif)
	);

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	logic [NUM_SRC-1:0] eligible;
	logic [NUM_SRC-1:0] hi_group;
	logic [5:0]         pick_hi;
	logic [5:0]         pick_any;
	logic [5:0]         pick;
	logic               reset_req;

	always_comb
	begin
		reset_req = ~reset_pin_n | watchdog_runaway;                      // see RQ13
		// unmasked, enabled, and above the level now in service
		eligible  = s_q.req_flags & ~mask_bit & {NUM_SRC{global_irq_enable}}; // see RQ5, RQ14
		if (in_service_level)
			eligible = eligible & ~level_select_flag;                     // see RQ14
		// high-level group first, then default order inside a group
		hi_group  = eligible & ~level_select_flag;
		pick_hi   = first_set(hi_group);
		pick_any  = first_set(eligible);
		pick      = pick_hi[5] ? pick_hi : pick_any;                      // see RQ4

		s_d            = s_q;
		s_d.sys_reset  = reset_req;
		s_d.break_trap = 1'b0;
		// clear by software or by the cpu taking it; a new pulse wins
		s_d.req_flags  = s_q.req_flags & ~req_flag_clr;
		if (irq_ack && s_q.irq_req)
			s_d.req_flags[s_q.irq_id] = 1'b0;
		s_d.req_flags  = s_d.req_flags | irq_src;                         // see RQ1, RQ2

		// break trap is unmaskable and outranks every maskable source
		if (break_exec)
		begin
			s_d.break_trap = 1'b1;                                        // see RQ3
			s_d.irq_req    = 1'b0;
			s_d.vector     = `ITSC_VEC_BREAK;                             // see RQ3
		end
		else
		begin
			s_d.irq_req = pick[5] && !(irq_ack && s_q.irq_req);
			s_d.irq_id  = pick[4:0];
			s_d.vector  = pick[5] ? vector_of(pick[4:0]) : s_q.vector;
		end

		// standby sequencing; any eligible request, unmasked test flag or break wakes
		unique case (s_q.standby)
			ST_RUN:
			begin
				if (stop_exec && !cpu_on_subclk)                          // see RQ11
					s_d.standby = ST_STOP;
				else if (halt_exec)
					s_d.standby = ST_HALT;
			end
			ST_HALT, ST_STOP:
			begin
				if (pick[5] || tif.test_wake || break_exec)
					s_d.standby = ST_RUN;
			end
			default:
				s_d.standby = ST_RUN;
		endcase
		s_d.cpu_clk_en  = (s_d.standby == ST_RUN);                        // see RQ9
		// stop bit only bites while the cpu is off the main clock
		s_d.main_osc_en = (s_d.standby != ST_STOP)                        // see RQ10
			&& !(main_clock_stop_bit && cpu_on_subclk);                    // see RQ11

		if (reset_req)
		begin
			s_d.req_flags  = `ITSC_FLAGS_RESET;
			s_d.irq_req    = 1'b0;
			s_d.break_trap = 1'b0;
			s_d.standby    = ST_RUN;
		end
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_q.req_flags   <= `ITSC_FLAGS_RESET;
			s_q.irq_req     <= 1'b0;
			s_q.irq_id      <= `ITSC_ID_RESET;
			s_q.vector      <= `ITSC_VEC_RESET;
			s_q.break_trap  <= 1'b0;
			s_q.standby     <= ST_RUN;
			s_q.cpu_clk_en  <= 1'b1;
			s_q.main_osc_en <= 1'b1;
			s_q.sys_reset   <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ------------------------------------------------------------------------
	assign irq_req     = s_q.irq_req;
	assign irq_id      = s_q.irq_id;
	assign irq_vector  = s_q.vector;
	assign break_trap  = s_q.break_trap;
	assign req_flags   = s_q.req_flags;
	assign test_flags  = tif.test_flags;
	assign test_wake   = tif.test_wake;
	assign cpu_clk_en  = s_q.cpu_clk_en;
	assign main_osc_en = s_q.main_osc_en;
	assign sys_reset   = s_q.sys_reset;

endmodule : interrupt_test_standby_ctrl

// *** sim/itsc_asserts.sv ***
/*
 * Port checker of the interrupt, test-input and standby controller top.
 * Assumes one core_clk domain and the synchronous rst of the design.
 */
`timescale 1ns/10ps
module itsc_asserts #(
	parameter int NUM_SRC = 20
)
(
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rst,
	input wire logic               reset_pin_n,
	input wire logic               watchdog_runaway,
	// controls
	input wire logic [NUM_SRC-1:0] irq_src,
	input wire logic [NUM_SRC-1:0] mask_bit,
	input wire logic               global_irq_enable,
	input wire logic               break_exec,
	input wire logic               halt_exec,
	input wire logic               stop_exec,
	input wire logic               cpu_on_subclk,
	input wire logic               main_clock_stop_bit,
	input wire logic               watch_overflow_test,
	input wire logic [1:0]         test_mask,
	// outputs
	input wire logic               irq_req,
	input wire logic [4:0]         irq_id,
	input wire logic [15:0]        irq_vector,
	input wire logic               break_trap,
	input wire logic [NUM_SRC-1:0] req_flags,
	input wire logic [1:0]         test_flags,
	input wire logic               test_wake,
	input wire logic               cpu_clk_en,
	input wire logic               main_osc_en,
	input wire logic               sys_reset
);
	logic [NUM_SRC-1:0] mask_q;
	logic [1:0]         tmask_q;
	logic               quiet;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// masks as the design saw them at the last edge
	always_ff @(posedge core_clk)
	begin
		mask_q  <= mask_bit;
		tmask_q <= test_mask;
	end
	// no wake cause pending, so a standby entry must stick
	assign quiet = reset_pin_n && !watchdog_runaway && !irq_req && !test_wake && !break_exec
		&& req_flags == '0 && cpu_clk_en;
	a_flag_set: assert property (
		reset_pin_n && !watchdog_runaway |=> (req_flags & $past(irq_src)) == $past(irq_src))
		else $error("request pulse did not set its flag");
	a_vector_map: assert property (irq_req |-> irq_vector == 16'h0004 + {10'h000, irq_id, 1'b0})
		else $error("vector does not match the selected source");
	a_break_trap: assert property (
		break_exec && reset_pin_n && !watchdog_runaway |=> break_trap && !irq_req && irq_vector == 16'h003E)
		else $error("break did not trap to its vector");
	a_gate_ok: assert property (irq_req |-> $past(global_irq_enable) && !mask_q[irq_id])
		else $error("masked or disabled request forwarded");
	a_halt_cpu: assert property (
		halt_exec && !stop_exec && !cpu_on_subclk && quiet |=> !cpu_clk_en && main_osc_en)
		else $error("halt did not stop only the cpu clock");
	a_stop_osc: assert property (stop_exec && !cpu_on_subclk && quiet |=> !cpu_clk_en && !main_osc_en)
		else $error("stop did not halt the main oscillator");
	a_stop_refuse: assert property (stop_exec && !halt_exec && cpu_on_subclk && quiet |=> cpu_clk_en)
		else $error("stop accepted on subsystem clock");
	a_osc_shutdown: assert property (cpu_on_subclk && main_clock_stop_bit |=> !main_osc_en)
		else $error("stop bit did not shut the main oscillator");
	a_reset_hold: assert property (!reset_pin_n || watchdog_runaway |=> sys_reset && !irq_req)
		else $error("reset source did not reset");
	a_reset_free: assert property (reset_pin_n && !watchdog_runaway |=> !sys_reset)
		else $error("system reset without a source");
	a_watch_set: assert property (watch_overflow_test |=> test_flags[0])
		else $error("watch overflow flag not set");
	a_wake_mask: assert property (test_wake == |(test_flags & ~tmask_q))
		else $error("test wake disagrees with flags and masks");
	c_halt: cover property (halt_exec && quiet);
	c_break: cover property (break_trap);
	c_adc: cover property (irq_req && irq_id == 5'h12);
endmodule : itsc_asserts

bind interrupt_test_standby_ctrl itsc_asserts #(.NUM_SRC(NUM_SRC)) itsc_asserts_i (.core_clk(core_clk), .rst(rst),
	.reset_pin_n(reset_pin_n), .watchdog_runaway(watchdog_runaway), .irq_src(irq_src), .mask_bit(mask_bit),
	.global_irq_enable(global_irq_enable), .break_exec(break_exec), .halt_exec(halt_exec), .stop_exec(stop_exec),
	.cpu_on_subclk(cpu_on_subclk), .main_clock_stop_bit(main_clock_stop_bit),
	.watch_overflow_test(watch_overflow_test), .test_mask(test_mask), .irq_req(irq_req), .irq_id(irq_id),
	.irq_vector(irq_vector), .break_trap(break_trap), .req_flags(req_flags), .test_flags(test_flags),
	.test_wake(test_wake), .cpu_clk_en(cpu_clk_en), .main_osc_en(main_osc_en), .sys_reset(sys_reset));

// *** sim/cpu_model.sv ***
/*
 * CPU side of the controller: acknowledges a standing request after a delay.
 * Assumes irq_req stays up until acknowledged.
 */
`timescale 1ns/10ps
module cpu_model (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// request side
	input wire logic       irq_req,
	input wire logic       auto_ack,
	input wire logic [3:0] ack_delay,
	output logic           irq_ack
);
	logic [3:0] wait_q;
	// one pulse a request; restarting after the pulse avoids a double ack
	always_ff @(posedge core_clk)
	begin
		if (rst || !irq_req || irq_ack)
		begin
			wait_q  <= 4'h0;
			irq_ack <= 1'b0;
		end
		else if (auto_ack && wait_q == ack_delay)
			irq_ack <= 1'b1;
		else
			wait_q <= wait_q + 4'h1;
	end
endmodule : cpu_model

// *** sim/tb_top.sv ***
/*
 * Self-checking bench of the controller with a cpu model.
 * Assumes inputs change at the falling edge of core_clk.
 */
`timescale 1ns/10ps
module tb_top;
	logic core_clk, rst, reset_pin_n, watchdog_runaway, global_irq_enable, in_service_level;
	logic irq_ack, break_exec, halt_exec, stop_exec, cpu_on_subclk, main_clock_stop_bit;
	logic watch_overflow_test, irq_req, break_trap, test_wake, cpu_clk_en, main_osc_en, sys_reset;
	logic [19:0] irq_src, mask_bit, level_select_flag, req_flag_clr, req_flags;
	logic [7:0]  port_falling_test;
	logic [1:0]  test_mask, test_clr, test_flags;
	logic [4:0]  irq_id;
	logic [15:0] irq_vector;
	logic        auto_ack;
	logic [3:0]  ack_delay;
	int          mismatches;
	int          comparisons;
	interrupt_test_standby_ctrl interrupt_test_standby_ctrl_i (.core_clk(core_clk), .rst(rst),
		.reset_pin_n(reset_pin_n), .watchdog_runaway(watchdog_runaway), .irq_src(irq_src), .mask_bit(mask_bit),
		.level_select_flag(level_select_flag), .req_flag_clr(req_flag_clr), .global_irq_enable(global_irq_enable),
		.in_service_level(in_service_level), .irq_ack(irq_ack), .break_exec(break_exec), .halt_exec(halt_exec),
		.stop_exec(stop_exec), .cpu_on_subclk(cpu_on_subclk), .main_clock_stop_bit(main_clock_stop_bit),
		.watch_overflow_test(watch_overflow_test), .port_falling_test(port_falling_test), .test_mask(test_mask),
		.test_clr(test_clr), .irq_req(irq_req), .irq_id(irq_id), .irq_vector(irq_vector), .break_trap(break_trap),
		.req_flags(req_flags), .test_flags(test_flags), .test_wake(test_wake), .cpu_clk_en(cpu_clk_en),
		.main_osc_en(main_osc_en), .sys_reset(sys_reset));
	cpu_model cpu_model_i (.core_clk(core_clk), .rst(rst), .irq_req(irq_req), .auto_ack(auto_ack),
		.ack_delay(ack_delay), .irq_ack(irq_ack));
	// 250 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task src_pulse(input logic [19:0] v);
		irq_src = v;
		cyc(1);
		irq_src = 20'h00000;
	endtask : src_pulse
	task want_irq(input logic [4:0] id, input logic [15:0] vec);
		chk({irq_req, irq_id, irq_vector}, {1'b1, id, vec});
	endtask : want_irq
	task tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// ------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------
	initial
	begin
		{watchdog_runaway, irq_src, mask_bit, level_select_flag, req_flag_clr, in_service_level} = '0;
		{break_exec, halt_exec, stop_exec, cpu_on_subclk, main_clock_stop_bit} = '0;
		{watch_overflow_test, test_mask, test_clr, auto_ack, ack_delay, mismatches, comparisons} = '0;
		{rst, reset_pin_n, global_irq_enable, port_falling_test} = {3'b111, 8'hFF};
		cyc(20);
		chk({cpu_clk_en, main_osc_en, irq_req, req_flags}, 23'h600000);
		rst = 1'b0;
		// adc, bus code write, same code written again; prompt and slow acks
		auto_ack = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			ack_delay = 4'(2 * i);
			src_pulse(20'h1 << (i == 0 ? 18 : 19));
			cyc(1);
			want_irq(i == 0 ? 5'h12 : 5'h13, i == 0 ? 16'h0028 : 16'h002A);
			cyc(8);
			chk(req_flags, 20'h00000);
		end
		// three at once, then level, mask, in-service and enable change the choice
		auto_ack = 1'b0;
		src_pulse(20'hC0008);
		cyc(1);
		want_irq(5'h03, 16'h000A);
		level_select_flag[3] = 1'b1;
		cyc(1);
		want_irq(5'h12, 16'h0028);
		mask_bit[18] = 1'b1;
		cyc(1);
		want_irq(5'h13, 16'h002A);
		// only low-level flags stay unmasked, so a low-level service blocks them all
		level_select_flag[19] = 1'b1;
		in_service_level = 1'b1;
		cyc(1);
		chk({irq_req, req_flags}, 21'h0C0008);
		in_service_level = 1'b0;
		global_irq_enable = 1'b0;
		cyc(1);
		chk({irq_req, req_flags}, 21'h0C0008);
		break_exec = 1'b1;
		cyc(1);
		break_exec = 1'b0;
		chk({break_trap, irq_vector}, 17'h1003E);
		cyc(1);
		chk(break_trap, 1'b0);
		{req_flag_clr, mask_bit, level_select_flag, in_service_level} = {20'hFFFFF, 41'h0};
		global_irq_enable = 1'b1;
		cyc(1);
		req_flag_clr = 20'h00000;
		cyc(1);
		chk({irq_req, req_flags}, 21'h000000);
		// test inputs: masked watch flag, unmasked port edge
		test_mask = 2'b01;
		watch_overflow_test = 1'b1;
		cyc(1);
		watch_overflow_test = 1'b0;
		chk({test_wake, test_flags}, 3'b001);
		port_falling_test = 8'hF7;
		cyc(1);
		chk({test_wake, test_flags}, 3'b111);
		{test_clr, test_mask, port_falling_test} = {4'hC, 8'hFF};
		cyc(1);
		test_clr = 2'b00;
		chk(test_flags, 2'b00);
		// halt wakes on a request, stop on a test flag
		auto_ack = 1'b1;
		halt_exec = 1'b1;
		cyc(1);
		halt_exec = 1'b0;
		chk({cpu_clk_en, main_osc_en}, 2'b01);
		cyc(2);
		src_pulse(20'h00020);
		cyc(1);
		chk({cpu_clk_en, irq_req}, 2'b11);
		cyc(8);
		stop_exec = 1'b1;
		cyc(1);
		stop_exec = 1'b0;
		chk({cpu_clk_en, main_osc_en}, 2'b00);
		watch_overflow_test = 1'b1;
		cyc(1);
		watch_overflow_test = 1'b0;
		cyc(1);
		chk({cpu_clk_en, main_osc_en}, 2'b11);
		test_clr = 2'b11;
		cyc(1);
		test_clr = 2'b00;
		// on the subsystem clock stop is refused and the stop bit shuts the oscillator
		cpu_on_subclk = 1'b1;
		stop_exec = 1'b1;
		cyc(1);
		stop_exec = 1'b0;
		chk(cpu_clk_en, 1'b1);
		main_clock_stop_bit = 1'b1;
		cyc(2);
		chk(main_osc_en, 1'b0);
		main_clock_stop_bit = 1'b0;
		cyc(8); // settling wait before the cpu returns to the main clock
		cpu_on_subclk = 1'b0;
		// reset pin, then watchdog runaway, each with a flag pending
		for (int i = 0; i < 2; i++)
		begin
			src_pulse(20'h00080);
			reset_pin_n = i[0];
			watchdog_runaway = i[0];
			cyc(1);
			chk({sys_reset, req_flags}, 21'h100000);
			reset_pin_n = 1'b1;
			watchdog_runaway = 1'b0;
			cyc(1);
			chk(sys_reset, 1'b0);
		end
		tally_and_finish;
	end
	// the sequence needs well under 1 us; a hang is cut short here
	initial
	begin
		#4000;
		mismatches++;
		tally_and_finish;
	end
endmodule : tb_top
